// ### common/dtb_pkg.sv
/*
 * Constants for the disk tag bus decoder: timing counts, bus bit
 * positions, register offsets, field positions and reset values.
 * Assumes a single 40 MHz clock and a synchronous active-high reset.
 */
// Notes on behaviour
// - Ready only at speed, loaded, no fault.
// - On-track while on track, drops on seek.
// - Offset command drops on-track for 1.0 ms.
// - 2.5 us track-start pulse, unaffected by seeks.
// - Unit lines compared only during select strobe.
// - Four lines name unit; missing plug means F.
// - Per-port busy when other unit holds drive; only port A does so, port B shows own selection, both in dual mode only.
// - Bus meaning follows the active tag.
// - Cylinder tag latches ten-bit binary cylinder.
// - Seek starts at cylinder tag falling edge.
// - Head tag latches bits 0 to 2.
// - Head register loads at head tag rise.
// - Bus bit 3 low selects the cartridge.
// - Control tag decodes each bit as command.
// - Unit selected within 400 ns on match.
// - Cylinder above 833 leaves seek-end unchanged.
`default_nettype none

package dtb_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned CNT_W     = 20;
  // Track-start pulse width in ns (2.5 us), rounded up to cycles.
  localparam int unsigned TSP_NS     = 2500;
  localparam int unsigned TSP_CYCLES = (TSP_NS + CLK_NS - 1) / CLK_NS;
  // Offset on-track drop in us (1.0 ms nominal).
  localparam int unsigned OFFSET_US  = 1000;
  localparam int unsigned OFFSET_CYCLES_DEF =
    OFFSET_US * (CLK_HZ / 1_000_000);
  // Plain defaults for revolution period and seek duration.
  localparam int unsigned REV_CYCLES_DEF  = 666_667;
  localparam int unsigned SEEK_CYCLES_DEF = 2000;

  // ==========================================================
  // Bus fields
  // ==========================================================
  localparam logic [9:0] CYL_MAX     = 10'h341;
  localparam logic [3:0] UNIT_ABSENT = 4'hf;
  localparam int HEAD_W     = 3;
  localparam int CART_BIT   = 3;
  localparam int CMD_WRITE  = 0;
  localparam int CMD_READ   = 1;
  localparam int CMD_OFS_FW = 2;
  localparam int CMD_OFS_RV = 3;
  localparam int CMD_FCLR   = 4;
  localparam int CMD_AMEN   = 5;
  localparam int CMD_RTZ    = 6;
  localparam int CMD_EARLY  = 7;
  localparam int CMD_LATE   = 8;
  localparam int CMD_PRIO   = 9;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CYL    = 8'h08;
  localparam logic [7:0] REG_HEAD   = 8'h0c;
  localparam logic [7:0] REG_CMD    = 8'h10;
  localparam int CTRL_DUAL   = 0;
  localparam int ST_ONTRK    = 0;
  localparam int ST_READY    = 1;
  localparam int ST_SEL      = 2;
  localparam int ST_SEEKERR  = 3;
  localparam int ST_INDEX    = 4;
  localparam int ST_OTHER    = 5;
  localparam logic CTRL_DUAL_RST = 1'h0;

  // Positioner states.
  typedef enum logic [1:0] {
    MOT_ON_TRACK,
    MOT_SEEKING,
    MOT_OFFSET
  } dtb_mot_t;

endpackage : dtb_pkg

`default_nettype wire

// ### core/dtb_timer.sv
/*
 * Down-counting one-shot timer used for seeks, offsets and the
 * revolution period.
 * Assumes start_i is a one-cycle request and len_i is at least 1.
 */
`default_nettype none

module dtb_timer
  import dtb_pkg::*;
(
  // Clock and reset.
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  // Control.
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] len_i,
  // Status.
  output logic                  busy_o,
  output logic                  done_o,
  output logic [CNT_W-1:0]      count_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // A start reloads, otherwise the count runs down to zero.
  always_comb begin
    next_cnt = cnt;
    if (start_i) begin
      next_cnt = len_i;
    end else if (cnt != '0) begin
      next_cnt = cnt - CNT_W'(1);
    end
  end

  // Count register.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Busy lasts exactly len_i cycles; done marks the last one.
  assign busy_o  = (cnt != '0);
  assign done_o  = (cnt == CNT_W'(1));
  assign count_o = cnt;

endmodule : dtb_timer

`default_nettype wire

// ### core/dtb_decoder.sv
/*
 * Drive-side decoder for the bussed tag interface: unit selection,
 * cylinder and head latching, control commands, positioner timing,
 * track-start pulse and an APB register slave.
 * Assumes all inputs are synchronous to ref_clk_i and that the
 * controller keeps its own tag timing.
 */
`default_nettype none

module dtb_decoder
  import dtb_pkg::*;
#(
  parameter logic [CNT_W-1:0] REV_CYCLES    = CNT_W'(REV_CYCLES_DEF),
  parameter logic [CNT_W-1:0] SEEK_CYCLES   = CNT_W'(SEEK_CYCLES_DEF),
  parameter logic [CNT_W-1:0] OFFSET_CYCLES = CNT_W'(OFFSET_CYCLES_DEF)
)(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // Unit selection.
  input  wire logic        unit_select_strobe_i,
  input  wire logic [3:0]  unit_address_lines_i,
  input  wire logic        plug_present_i,
  input  wire logic [3:0]  plug_address_i,
  input  wire logic        degate_i,
  output logic             unit_selected_out_o,
  // Tags and bus.
  input  wire logic        cylinder_address_strobe_i,
  input  wire logic        head_address_strobe_i,
  input  wire logic        control_command_strobe_i,
  input  wire logic [9:0]  command_bus_lines_i,
  // Drive condition.
  input  wire logic        at_speed_i,
  input  wire logic        heads_loaded_i,
  input  wire logic        fault_i,
  input  wire logic        other_unit_holds_i,
  // Status toward the controller.
  output logic             drive_ready_out_o,
  output logic             on_track_out_o,
  output logic             track_start_pulse_o,
  output logic             port_a_other_owner_o,
  output logic             port_b_other_owner_o,
  // Decoded state toward the drive.
  output logic [9:0]       cylinder_o,
  output logic [2:0]       head_o,
  output logic             cartridge_select_bit_o,
  output logic [9:0]       cmd_bits_o,
  output logic             seek_error_o,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  // ==========================================================
  // Unit selection and tag edges
  // ==========================================================
  logic       cyl_tag_q;
  logic       hd_tag_q;
  logic [3:0] my_addr;
  logic       next_sel;
  logic       sel_act;
  logic       cyl_fall;
  logic       hd_rise;

  // A missing plug reads as the highest unit number.
  assign my_addr = plug_present_i ? plug_address_i : UNIT_ABSENT;

  // The address lines matter only while the strobe is high.
  always_comb begin
    next_sel = unit_selected_out_o;
    if (unit_select_strobe_i) begin
      next_sel = (unit_address_lines_i == my_addr) && !degate_i;
    end
  end

  // Tags act only while this drive is selected.
  assign sel_act  = unit_selected_out_o;
  assign cyl_fall = sel_act && cyl_tag_q && !cylinder_address_strobe_i;
  assign hd_rise  = sel_act && head_address_strobe_i && !hd_tag_q;

  // Selection and tag history registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      unit_selected_out_o <= 1'h0;
      cyl_tag_q           <= 1'h0;
      hd_tag_q            <= 1'h0;
    end else begin
      unit_selected_out_o <= next_sel;
      cyl_tag_q           <= cylinder_address_strobe_i;
      hd_tag_q            <= head_address_strobe_i;
    end
  end

  // ==========================================================
  // Address latches and command decode
  // ==========================================================
  logic [9:0] target_cyl;
  logic [9:0] next_target;
  logic [2:0] next_head;
  logic       next_cart;
  logic [9:0] next_cmd;
  logic [9:0] cmd_rise;
  logic [9:0] cmd_prev;

  // Bus meaning follows whichever tag is active.
  always_comb begin
    next_target = target_cyl;
    next_head   = head_o;
    next_cart   = cartridge_select_bit_o;
    next_cmd    = 10'h000;
    if (sel_act && cylinder_address_strobe_i) begin
      next_target = command_bus_lines_i;
    end
    if (hd_rise) begin
      next_head = command_bus_lines_i[HEAD_W-1:0];
      next_cart = !command_bus_lines_i[CART_BIT];
    end
    if (sel_act && control_command_strobe_i) begin
      next_cmd = command_bus_lines_i;
    end
  end

  // A command fires once when its bit first appears.
  assign cmd_rise = cmd_bits_o & ~cmd_prev;

  // Latch registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      target_cyl             <= 10'h000;
      head_o                 <= 3'h0;
      cartridge_select_bit_o <= 1'h0;
      cmd_bits_o             <= 10'h000;
      cmd_prev               <= 10'h000;
    end else begin
      target_cyl             <= next_target;
      head_o                 <= next_head;
      cartridge_select_bit_o <= next_cart;
      cmd_bits_o             <= next_cmd;
      cmd_prev               <= cmd_bits_o;
    end
  end

  // ==========================================================
  // Positioner
  // ==========================================================
  dtb_mot_t         mot;
  dtb_mot_t         next_mot;
  logic             next_ontrk;
  logic             next_serr;
  logic [9:0]       next_cylreg;
  logic             mot_start;
  logic [CNT_W-1:0] mot_len;
  logic             mot_done;
  logic             offset_go;
  logic             rtz_go;

  assign offset_go = cmd_rise[CMD_OFS_FW] || cmd_rise[CMD_OFS_RV];
  assign rtz_go    = cmd_rise[CMD_RTZ];

  // Seeks, rezero and offsets share one timer.
  always_comb begin
    next_mot    = mot;
    next_serr   = seek_error_o;
    next_cylreg = cylinder_o;
    mot_start   = 1'h0;
    mot_len     = SEEK_CYCLES;
    case (mot)
      MOT_ON_TRACK: begin
        if (cyl_fall && (target_cyl > CYL_MAX)) begin
          next_serr = 1'h1;
        end else if (cyl_fall) begin
          next_mot    = MOT_SEEKING;
          next_cylreg = target_cyl;
          mot_start   = 1'h1;
        end else if (offset_go) begin
          next_mot  = MOT_OFFSET;
          mot_start = 1'h1;
          mot_len   = OFFSET_CYCLES;
        end
      end
      MOT_SEEKING, MOT_OFFSET: begin
        if (mot_done) begin
          next_mot = MOT_ON_TRACK;
        end
      end
      default: begin
        next_mot = MOT_ON_TRACK;
      end
    endcase
    // Rezero is taken in any state, except in the cycle of an out-of-range cylinder tag fall, and clears a seek error.
    if (rtz_go && !(cyl_fall && (target_cyl > CYL_MAX))) begin
      next_mot    = MOT_SEEKING;
      next_cylreg = 10'h000;
      next_serr   = 1'h0;
      mot_start   = 1'h1;
      mot_len     = SEEK_CYCLES;
    end
    next_ontrk = (next_mot == MOT_ON_TRACK);
  end

  dtb_timer u_mot_timer (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .start_i   (mot_start),
    .len_i     (mot_len),
    .busy_o    (),
    .done_o    (mot_done),
    .count_o   ()
  );

  // Positioner registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mot            <= MOT_ON_TRACK;
      on_track_out_o <= 1'h1;
      seek_error_o   <= 1'h0;
      cylinder_o     <= 10'h000;
    end else begin
      mot            <= next_mot;
      on_track_out_o <= next_ontrk;
      seek_error_o   <= next_serr;
      cylinder_o     <= next_cylreg;
    end
  end

  // ==========================================================
  // Track start, ready and port busy
  // ==========================================================
  logic             idx_busy;
  logic             idx_done;
  logic [CNT_W-1:0] idx_cnt;
  logic             next_tsp;
  logic             next_ready;
  logic             next_pa;
  logic             next_pb;
  logic             dual_en;

  // The revolution timer runs free of the positioner.
  dtb_timer u_idx_timer (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .start_i   (idx_done || !idx_busy),
    .len_i     (REV_CYCLES),
    .busy_o    (idx_busy),
    .done_o    (idx_done),
    .count_o   (idx_cnt)
  );

  // Status levels computed from the drive condition.
  always_comb begin
    next_tsp   = idx_busy &&
                 (idx_cnt > (REV_CYCLES - CNT_W'(TSP_CYCLES)));
    next_ready = sel_act && at_speed_i && heads_loaded_i
                 && !fault_i;
    next_pa    = dual_en && other_unit_holds_i;
    next_pb    = dual_en && sel_act;
  end

  // Status registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      track_start_pulse_o  <= 1'h0;
      drive_ready_out_o    <= 1'h0;
      port_a_other_owner_o <= 1'h0;
      port_b_other_owner_o <= 1'h0;
    end else begin
      track_start_pulse_o  <= next_tsp;
      drive_ready_out_o    <= next_ready;
      port_a_other_owner_o <= next_pa;
      port_b_other_owner_o <= next_pb;
    end
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  logic [31:0] next_rdata;
  logic        next_err;
  logic        next_dual;
  logic        setup;

  assign setup    = psel_i && !penable_i;
  assign pready_o = psel_i && penable_i;

  // Read data and error are prepared in the setup cycle.
  always_comb begin
    next_rdata = prdata_o;
    next_err   = pslverr_o;
    next_dual  = dual_en;
    if (setup) begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'h0;
      case (paddr_i)
        REG_CTRL:   next_rdata[CTRL_DUAL] = dual_en;
        REG_STATUS: begin
          next_rdata[ST_ONTRK]   = on_track_out_o;
          next_rdata[ST_READY]   = drive_ready_out_o;
          next_rdata[ST_SEL]     = unit_selected_out_o;
          next_rdata[ST_SEEKERR] = seek_error_o;
          next_rdata[ST_INDEX]   = track_start_pulse_o;
          next_rdata[ST_OTHER]   = port_a_other_owner_o;
        end
        REG_CYL:    next_rdata[9:0] = cylinder_o;
        REG_HEAD:   next_rdata[3:0] = {cartridge_select_bit_o, head_o};
        REG_CMD:    next_rdata[9:0] = cmd_bits_o;
        default:    next_err = 1'h1;
      endcase
    end
    if (pready_o && pwrite_i && (paddr_i == REG_CTRL)) begin
      next_dual = pwdata_i[CTRL_DUAL];
    end
  end

  // Bus registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'h0;
      dual_en   <= CTRL_DUAL_RST;
    end else begin
      prdata_o  <= next_rdata;
      pslverr_o <= next_err;
      dual_en   <= next_dual;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  localparam int TSP_LAST = TSP_CYCLES - 1;
  logic [CNT_W-1:0] low_run;
  logic [CNT_W-1:0] tsp_run;

  // Length of the current on-track low stretch.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || on_track_out_o) begin
      low_run <= '0;
    end else begin
      low_run <= low_run + CNT_W'(1);
    end
  end

  // Length of the current track-start pulse, too long to unroll.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !track_start_pulse_o) begin
      tsp_run <= '0;
    end else begin
      tsp_run <= tsp_run + CNT_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence good_seek_s;
    cyl_fall && (target_cyl <= CYL_MAX) && (mot == MOT_ON_TRACK);
  endsequence

  sequence far_seek_s;
    cyl_fall && (target_cyl > CYL_MAX);
  endsequence

  ready_cond_a: assert property (
    ##1 drive_ready_out_o == $past(sel_act && at_speed_i &&
                                   heads_loaded_i && !fault_i))
    else $error("Ready does not follow drive condition.");

  seek_drop_a: assert property (
    good_seek_s |=> !on_track_out_o && (cylinder_o == $past(target_cyl)))
    else $error("Accepted seek kept on-track high.");

  offset_drop_a: assert property (
    (mot == MOT_ON_TRACK) && offset_go && !cyl_fall && !rtz_go
      |=> !on_track_out_o [*8])
    else $error("Offset did not drop on-track.");

  offset_len_a: assert property (
    $rose(on_track_out_o) && ($past(mot) == MOT_OFFSET)
      |-> $past(low_run) == OFFSET_CYCLES - CNT_W'(1))
    else $error("Offset on-track drop has wrong length.");

  index_width_a: assert property (
    $fell(track_start_pulse_o) |-> $past(tsp_run) == CNT_W'(TSP_LAST))
    else $error("Track-start pulse has wrong width.");

  unit_match_a: assert property (
    unit_select_strobe_i && (unit_address_lines_i == my_addr)
      && !degate_i |=> unit_selected_out_o)
    else $error("Matching unit was not selected.");

  unit_hold_a: assert property (
    !unit_select_strobe_i |=> $stable(unit_selected_out_o))
    else $error("Selection changed without select strobe.");

  cyl_latch_a: assert property (
    sel_act && cylinder_address_strobe_i
      |=> target_cyl == $past(command_bus_lines_i))
    else $error("Cylinder address not latched.");

  head_latch_a: assert property (
    hd_rise |=> (head_o == $past(command_bus_lines_i[HEAD_W-1:0]))
      && (cartridge_select_bit_o == !$past(command_bus_lines_i[CART_BIT])))
    else $error("Head address or cartridge bit not loaded.");

  cmd_gate_a: assert property (
    !(sel_act && control_command_strobe_i) |=> cmd_bits_o == 10'h000)
    else $error("Command bits seen outside control tag.");

  far_cyl_a: assert property (
    far_seek_s |=> $stable(on_track_out_o) && seek_error_o)
    else $error("Out-of-range cylinder changed seek-end status.");

  port_busy_a: assert property (
    ##1 port_a_other_owner_o == $past(dual_en && other_unit_holds_i))
    else $error("Port busy does not track the other unit.");

endmodule : dtb_decoder

`default_nettype wire

// ### bench/dtb_ctl_model.sv
/*
 * Controller model that drives the unit-select and tag bus lines.
 * Assumes the bench calls its tasks one at a time on ref_clk_i.
 */
`default_nettype none

module dtb_ctl_model
  import dtb_pkg::*;
(
  // Clock and drive status.
  input  wire logic  ref_clk_i,
  input  wire logic  on_track_i,
  // Selection lines.
  output logic       unit_select_strobe_o,
  output logic [3:0] unit_address_lines_o,
  // Tags and bus.
  output logic       cylinder_address_strobe_o,
  output logic       head_address_strobe_o,
  output logic       control_command_strobe_o,
  output logic [9:0] command_bus_lines_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Line drivers
  // ==========================================================
  logic [2:0] tag_q;

  // One tag bit per strobe keeps the strobes mutually exclusive.
  assign cylinder_address_strobe_o = tag_q[0];
  assign head_address_strobe_o     = tag_q[1];
  assign control_command_strobe_o  = tag_q[2];

  // Lines start idle.
  initial begin
    tag_q                = 3'h0;
    unit_select_strobe_o = 1'b0;
    unit_address_lines_o = 4'h0;
    command_bus_lines_o  = 10'h000;
  end

  // Strobe a unit number, then release the lines inverted.
  task automatic unit_sel(input logic [3:0] u);
    @(posedge ref_clk_i);
    unit_address_lines_o <= u;
    unit_select_strobe_o <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    unit_select_strobe_o <= 1'b0;
    unit_address_lines_o <= ~u;
    repeat (8) @(posedge ref_clk_i);
  endtask : unit_sel

  // One tag cycle: 0 cylinder, 1 head, 2 control.
  task automatic tag_cycle(input int which, input logic [9:0] v);
    int n;
    n = 0;
    // A cylinder tag waits until the drive is on track.
    while (which == 0 && on_track_i !== 1'b1 && n < 400) begin
      @(posedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    command_bus_lines_o <= v;
    repeat (8) @(posedge ref_clk_i);
    tag_q <= 3'h1 << which;
    repeat (32) @(posedge ref_clk_i);
    tag_q <= 3'h0;
    repeat (8) @(posedge ref_clk_i);
    command_bus_lines_o <= ~v; // Released bus shows no stale value.
    repeat (40) @(posedge ref_clk_i);
  endtask : tag_cycle

endmodule : dtb_ctl_model

`default_nettype wire

// ### bench/disk_tag_bus_decoder_bench.sv
/*
 * Self-checking bench for the tag bus decoder with a controller model.
 * Assumes short seek, offset and revolution counts set below.
 */
`default_nettype none

module disk_tag_bus_decoder_bench
  import dtb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  // ==========================================================
  localparam int SEEK_N = 20;
  localparam int OFS_N  = 30;
  localparam int REV_N  = 300;
  logic        clk, srst, plug_in, degate, speed, loaded, fault, holds;
  logic        psel, penable, pwrite, sel, ready, on_trk, tsp, pa, pb;
  logic        cart, serr, pready, pslverr, usel, ctag, htag, xtag;
  logic        ctl_d, tsp_d, trk_d;
  logic [3:0]  plug_addr, ulines;
  logic [7:0]  paddr;
  logic [9:0]  bus, cyl, cmd, acc;
  logic [2:0]  head;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  int          fail_count, samples_checked, cycles;
  int          run, last_low, drops, hi, hi_len, per, per_len;

  dtb_decoder #(.REV_CYCLES(CNT_W'(REV_N)), .SEEK_CYCLES(CNT_W'(SEEK_N)),
    .OFFSET_CYCLES(CNT_W'(OFS_N))) dtb_decoder_inst (
    .ref_clk_i(clk), .srst_i(srst), .unit_select_strobe_i(usel),
    .unit_address_lines_i(ulines), .plug_present_i(plug_in),
    .plug_address_i(plug_addr), .degate_i(degate),
    .unit_selected_out_o(sel), .cylinder_address_strobe_i(ctag),
    .head_address_strobe_i(htag), .control_command_strobe_i(xtag),
    .command_bus_lines_i(bus), .at_speed_i(speed),
    .heads_loaded_i(loaded), .fault_i(fault),
    .other_unit_holds_i(holds), .drive_ready_out_o(ready),
    .on_track_out_o(on_trk), .track_start_pulse_o(tsp),
    .port_a_other_owner_o(pa), .port_b_other_owner_o(pb),
    .cylinder_o(cyl), .head_o(head), .cartridge_select_bit_o(cart),
    .cmd_bits_o(cmd), .seek_error_o(serr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));

  dtb_ctl_model dtb_ctl_model_inst (
    .ref_clk_i(clk), .on_track_i(on_trk), .unit_select_strobe_o(usel),
    .unit_address_lines_o(ulines), .cylinder_address_strobe_o(ctag),
    .head_address_strobe_o(htag), .control_command_strobe_o(xtag),
    .command_bus_lines_o(bus));

  // Clock of 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Measures low stretches, pulse widths and captured commands.
  always @(posedge clk) begin
    trk_d <= on_trk;
    tsp_d <= tsp;
    ctl_d <= xtag;
    run <= on_trk ? 0 : run + 1;
    if (on_trk && !trk_d) last_low <= run;
    if (!on_trk && trk_d) drops <= drops + 1;
    hi <= tsp ? hi + 1 : 0;
    if (!tsp && tsp_d) hi_len <= hi;
    per <= (tsp && !tsp_d) ? 1 : per + 1;
    if (tsp && !tsp_d) per_len <= per;
    acc <= (xtag && !ctl_d) ? 10'h000 : acc | cmd;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; waits for pready with the request held.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_regs();
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    chk("ctrl err", 32'h0, 32'(er));
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl back", 32'h1, rd);
    apb(1'b1, REG_CTRL, 32'h0);
  endtask : t_regs

  task automatic t_select();
    dtb_ctl_model_inst.unit_sel(4'hf);
    chk("sel no plug", 32'h1, 32'(sel));
    dtb_ctl_model_inst.unit_sel(4'h3);
    chk("sel mismatch", 32'h0, 32'(sel));
    @(posedge clk);
    plug_in <= 1'b1;
    plug_addr <= 4'h3;
    dtb_ctl_model_inst.unit_sel(4'h3);
    chk("sel held", 32'h1, 32'(sel));
    @(posedge clk);
    degate <= 1'b1;
    dtb_ctl_model_inst.unit_sel(4'h3);
    chk("sel degate", 32'h0, 32'(sel));
    @(posedge clk);
    degate <= 1'b0;
    dtb_ctl_model_inst.unit_sel(4'h3);
  endtask : t_select

  task automatic t_ready();
    logic [2:0] tb [4] = '{3'b110, 3'b010, 3'b100, 3'b111};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {speed, loaded, fault} <= tb[i];
      repeat (3) @(posedge clk);
      chk("ready", 32'(i == 0), 32'(ready));
    end
  endtask : t_ready

  task automatic t_seek();
    logic [9:0] v [2] = '{10'h0be, 10'h341};
    int n;
    foreach (v[i]) begin
      dtb_ctl_model_inst.tag_cycle(0, v[i]);
      chk("cylinder", 32'(v[i]), 32'(cyl));
      chk("seek low", SEEK_N, last_low);
    end
    n = drops;
    dtb_ctl_model_inst.tag_cycle(0, 10'h342);
    chk("no seek", n, drops);
    chk("seek err", 32'h1, 32'(serr));
    apb(1'b0, REG_CYL, 32'h0);
    chk("cyl reg", 32'h341, rd);
  endtask : t_seek

  task automatic t_head();
    dtb_ctl_model_inst.tag_cycle(1, 10'h3f5);
    chk("head", 32'h5, 32'(head));
    chk("cart on", 32'h1, 32'(cart));
    dtb_ctl_model_inst.tag_cycle(1, 10'h00a);
    chk("head", 32'h2, 32'(head));
    chk("cart off", 32'h0, 32'(cart));
    apb(1'b0, REG_HEAD, 32'h0);
    chk("head reg", 32'h2, rd);
  endtask : t_head

  task automatic t_ctl();
    for (int b = 0; b < 10; b++) begin
      dtb_ctl_model_inst.tag_cycle(2, 10'h001 << b);
      chk("cmd seen", 32'h1 << b, 32'(acc));
      chk("cmd idle", 32'h0, 32'(cmd));
      if (b == CMD_OFS_FW || b == CMD_OFS_RV)
        chk("offset low", OFS_N, last_low);
      if (b == CMD_RTZ) begin
        chk("rtz cyl", 32'h0, 32'(cyl));
        chk("rtz err", 32'h0, 32'(serr));
        chk("rtz low", SEEK_N, last_low);
      end
    end
  endtask : t_ctl

  task automatic t_dual();
    apb(1'b1, REG_CTRL, 32'h1);
    holds <= 1'b1;
    repeat (3) @(posedge clk);
    chk("port a", 32'h1, 32'(pa));
    chk("port b", 32'h1, 32'(pb));
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status busy", 32'h1, 32'(rd[ST_OTHER]));
    holds <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk("port a off", 32'h0, 32'(pa));
    chk("port b off", 32'h0, 32'(pb));
  endtask : t_dual

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    {srst, plug_in, degate, speed, loaded, fault, holds} = 7'h40;
    {psel, penable, pwrite, paddr, pwdata, plug_addr} = '0;
    {fail_count, samples_checked, cycles, run, drops, hi, per} = '0;
    {last_low, hi_len, per_len, acc, ctl_d, tsp_d, trk_d} = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_select();
    t_ready();
    t_seek();
    t_head();
    t_ctl();
    t_dual();
    chk("index width", TSP_CYCLES, hi_len);
    chk("index period", REV_N, per_len);
    tally_and_finish();
  end

endmodule : disk_tag_bus_decoder_bench

`default_nettype wire
